// [shared/crypto_sup_pkg.sv]
// Purpose: Constants shared by the crypto supervisor and its bench.
// Assumes: 250 MHz core clock, plain register port with 32-bit data.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package crypto_sup_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;  // Operator controls
  localparam logic [7:0] STAT_OFS   = 8'h04;  // Indicators and state
  localparam logic [7:0] FAULT_OFS  = 8'h08;  // Latched alarm causes
  // Control register fields
  localparam int CTRL_STANDBY   = 0;
  localparam int CTRL_SECURE    = 1;
  localparam int CTRL_TEST      = 2;
  localparam int CTRL_LAMP      = 3;
  localparam int CTRL_BYPASS    = 4;
  localparam int CTRL_CBC       = 5;
  localparam int CTRL_ALM_RST   = 6;   // Write-one pulse
  localparam int CTRL_ZEROIZE   = 7;   // Write-one pulse
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Status register fields
  localparam int STAT_POWER     = 0;
  localparam int STAT_BYPASS    = 1;
  localparam int STAT_TEST      = 2;
  localparam int STAT_BATTERY   = 3;
  localparam int STAT_ALARM     = 4;
  localparam int STAT_PARITY    = 5;
  localparam int STAT_CT_EN     = 6;
  localparam int STAT_ZEROED    = 7;
  localparam int STAT_KEY_OK    = 8;
  localparam int STAT_CHECKING  = 9;
  localparam int NUM_CHECKS     = 4;     // Fault sources rerun on reset
  // Timing: recheck window in ns and derived cycles
  localparam int CLK_PERIOD_NS  = 4;
  localparam int RECHECK_NS     = 40;
  localparam int RECHECK_CYC    = (RECHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIPE_WORDS     = 8;     // Key plus vector words to erase
endpackage : crypto_sup_pkg
`default_nettype wire

// [verilog/crypto_sup.sv]
// Purpose: Security supervisor: controls, indicators, ciphertext inhibit.
// Assumes: All inputs synchronous to clk_i; registers on a plain port.
// Notes:   Key store is erased word by word; the cipher core is outside.
//
// How it works
// - Power off wipes storage and drops power
// - Standby disables cipher, keeps key
// - Alarm reset reruns all fault checks
// - Alarm exits only when every check passes
// - Ciphertext inhibited throughout alarm and recheck
// - Test mode runs table and alarm checks
// - Key entry inhibits ciphertext while it lasts
// - Bypass may pass plaintext during alarm
// - Secure mode enciphers transmit, deciphers receive
// - Zeroize erases keys and CBC vector
// - Bypass indicator when not enciphering
// - Test indicator while in test mode
// - Battery indicator shows retention health
// - Alarm indicator on error or tamper
// - Alarm kills ciphertext at once, bypass or not
// - Audible relay follows alarm lamp exactly
// - Parity indicator on key entry parity error
// - Parity error blocks transfers until good key
// - Lamp test lights every indicator
// - Power indicator while power is good
// - Test mode inhibits, uses test key only
// - Zeroization inhibits ciphertext
`default_nettype none
module crypto_sup #(
  parameter int KEY_W = 64  // Key storage word width
) (
  input  wire logic              clk_i,          // 250 MHz clock
  input  wire logic              arst_n_i,       // Async reset, low
  input  wire logic [7:0]        addr_i,         // Register byte address
  input  wire logic [31:0]       wdata_i,        // Write data
  input  wire logic              wr_i,           // Write strobe
  input  wire logic              rd_i,           // Read strobe
  output logic      [31:0]       rdata_o,        // Read data, next cycle
  input  wire logic              power_sw_on_i,  // Power switch level
  input  wire logic              power_good_i,   // Supply within limits
  input  wire logic              battery_ok_i,   // Battery healthy
  input  wire logic [crypto_sup_pkg::NUM_CHECKS-1:0] fault_i, // Live checks
  input  wire logic              sbox_ok_i,      // Table check result
  input  wire logic              key_entry_i,    // Key load in progress
  input  wire logic              key_parity_err_i, // Parity error pulse
  input  wire logic              key_load_done_i,  // Good key finished
  input  wire logic              xfer_req_i,     // Internal key transfer
  output logic                   xfer_grant_o,   // Transfer allowed
  output logic                   ct_enable_o,    // Ciphertext output on
  output logic                   bypass_route_o, // Plaintext path on
  output logic                   engine_run_o,   // Cipher engine active
  output logic                   use_test_key_o, // Select test key
  output logic                   primary_off_o,  // Drop primary power
  output logic                   battery_off_o,  // Drop battery power
  output logic                   wipe_we_o,      // Key store write
  output logic [2:0]             wipe_addr_o,    // Key store word
  output logic [KEY_W-1:0]       wipe_data_o,    // Zero pattern
  output logic                   ind_power_o,    // Indicators
  output logic                   ind_bypass_o,
  output logic                   ind_test_o,
  output logic                   ind_battery_o,
  output logic                   ind_alarm_o,
  output logic                   ind_parity_o,
  output logic                   relay_alarm_o   // Dry-contact drive
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  typedef enum logic [1:0] {ALM_IDLE, ALM_LATCHED, ALM_CHECK} alm_e;
  alm_e                          alm_state;      // Alarm machine
  logic [7:0]                    ctrl;           // Held operator controls
  logic [crypto_sup_pkg::NUM_CHECKS:0] fault_lat; // Causes, bit 4 = table
  logic [7:0]                    chk_cnt;        // Recheck window count
  logic                          chk_fail;       // Failure seen in recheck
  logic                          parity_lock;    // Transfers blocked
  logic                          parity_flag;    // Parity indicator
  logic                          wiping;         // Erase in progress
  logic                          zeroed;         // Storage erased
  logic [3:0]                    wipe_cnt;       // Erase word counter
  logic                          any_fault;      // Live fault present
  logic                          alarm;          // Alarm condition
  logic                          ct_ok;          // Enable term

  wire wr_ctrl   = wr_i && (addr_i == crypto_sup_pkg::CTRL_OFS);
  wire alm_rst   = wr_ctrl && wdata_i[crypto_sup_pkg::CTRL_ALM_RST];
  wire zero_cmd  = wr_ctrl && wdata_i[crypto_sup_pkg::CTRL_ZEROIZE];
  wire test_mode = ctrl[crypto_sup_pkg::CTRL_TEST];
  wire lamp      = ctrl[crypto_sup_pkg::CTRL_LAMP];
  wire standby   = ctrl[crypto_sup_pkg::CTRL_STANDBY];
  // Table check runs only in test mode, so it only counts there
  wire sbox_bad  = test_mode && !sbox_ok_i;
  wire power_off = !power_sw_on_i;

  assign any_fault = (|fault_i) || sbox_bad;
  assign alarm     = (alm_state != ALM_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Control register; pulse bits are not stored

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= crypto_sup_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= {2'h0, wdata_i[5:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault cause latch; set wins over the clear done by a good recheck

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_lat <= '0;
    end else if (alm_state == ALM_CHECK && chk_cnt == 8'h00 && !chk_fail && !any_fault) begin
      fault_lat <= '0;
    end else begin
      fault_lat <= fault_lat | {sbox_bad, fault_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm machine: latched alarm, reset reruns checks over a window

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alm_state <= ALM_IDLE;
      chk_cnt   <= 8'h00;
      chk_fail  <= 1'b0;
    end else begin
      case (alm_state)
        ALM_IDLE: begin
          if (any_fault) begin
            alm_state <= ALM_LATCHED;
          end
        end
        ALM_LATCHED: begin
          // Fault going away alone never clears the alarm
          if (alm_rst) begin
            alm_state <= ALM_CHECK;
            chk_cnt   <= 8'(crypto_sup_pkg::RECHECK_CYC - 1);
            chk_fail  <= any_fault;
          end
        end
        ALM_CHECK: begin
          // Every check sampled across the window must stay clean
          if (chk_fail || any_fault) begin
            alm_state <= ALM_LATCHED;
            chk_fail  <= 1'b0;
          end else if (chk_cnt == 8'h00) begin
            alm_state <= ALM_IDLE;
          end else begin
            chk_cnt <= chk_cnt - 8'h01;
          end
        end
        default: begin
          alm_state <= ALM_LATCHED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parity lock: blocks transfers until a good key arrives

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      parity_lock <= 1'b0;
      parity_flag <= 1'b0;
    end else if (key_parity_err_i) begin
      parity_lock <= 1'b1;
      parity_flag <= 1'b1;
    end else if (key_load_done_i) begin
      parity_lock <= 1'b0;
      parity_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Zeroization: walks key words, plus vector words in CBC

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wiping   <= 1'b0;
      zeroed   <= 1'b0;
      wipe_cnt <= 4'h0;
    end else if (zero_cmd || (power_off && !wiping && !zeroed)) begin
      wiping   <= 1'b1;
      wipe_cnt <= 4'h0;
    end else if (wiping) begin
      // Key words in lower half; vector words only erased in CBC
      if (wipe_cnt == 4'(crypto_sup_pkg::WIPE_WORDS - 1) ||
          (!ctrl[crypto_sup_pkg::CTRL_CBC] && wipe_cnt == 4'(crypto_sup_pkg::WIPE_WORDS / 2 - 1))) begin
        wiping <= 1'b0;
        zeroed <= 1'b1;
      end
      wipe_cnt <= wipe_cnt + 4'h1;
    end else if (key_load_done_i && !power_off) begin
      zeroed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ciphertext enable term

  always_comb begin
    // Standby keeps the key but stops the engine
    // Live fault term cuts ciphertext one edge before the alarm latch could
    ct_ok = !alarm && !any_fault && !test_mode && !key_entry_i && !wiping && !zeroed &&
            ctrl[crypto_sup_pkg::CTRL_SECURE] && !standby && !power_off;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ct_enable_o    <= 1'b0;
      bypass_route_o <= 1'b0;
      engine_run_o   <= 1'b0;
      use_test_key_o <= 1'b0;
      xfer_grant_o   <= 1'b0;
      primary_off_o  <= 1'b0;
      battery_off_o  <= 1'b0;
    end else begin
      ct_enable_o    <= ct_ok;
      // Plaintext path only on request with bypass control fitted
      bypass_route_o <= ctrl[crypto_sup_pkg::CTRL_BYPASS] && !ct_ok;
      engine_run_o   <= !standby && !zeroed && !wiping && !power_off;
      use_test_key_o <= test_mode;
      xfer_grant_o   <= xfer_req_i && !parity_lock && !key_parity_err_i;
      // Power is released only once storage is clean
      primary_off_o  <= power_off && zeroed;
      battery_off_o  <= power_off && zeroed;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wipe_we_o   <= 1'b0;
      wipe_addr_o <= 3'h0;
      wipe_data_o <= '0;
    end else begin
      wipe_we_o   <= wiping;
      wipe_addr_o <= wipe_cnt[2:0];
      wipe_data_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Indicators; lamp test forces every lamp on

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ind_power_o   <= 1'b0;
      ind_bypass_o  <= 1'b0;
      ind_test_o    <= 1'b0;
      ind_battery_o <= 1'b0;
      ind_alarm_o   <= 1'b0;
      ind_parity_o  <= 1'b0;
      relay_alarm_o <= 1'b0;
    end else begin
      ind_power_o   <= lamp || (power_good_i && !power_off);
      ind_bypass_o  <= lamp || !ct_ok;
      ind_test_o    <= lamp || test_mode;
      ind_battery_o <= lamp || battery_ok_i;
      ind_alarm_o   <= lamp || alarm || any_fault;
      ind_parity_o  <= lamp || parity_flag;
      // Relay copies the lamp drive so it tracks exactly
      relay_alarm_o <= lamp || alarm || any_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after the strobe

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        crypto_sup_pkg::CTRL_OFS:  rdata_o <= {24'h0, ctrl};
        crypto_sup_pkg::STAT_OFS:  rdata_o <= {22'h0, alm_state == ALM_CHECK, !parity_lock, zeroed, ct_enable_o,
                                               ind_parity_o, ind_alarm_o, ind_battery_o, ind_test_o,
                                               ind_bypass_o, ind_power_o};
        crypto_sup_pkg::FAULT_OFS: rdata_o <= {27'h0, fault_lat};
        default:                   rdata_o <= 32'h0;  // Unmapped reads zero
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_reset_req;
    alm_state == ALM_LATCHED && alm_rst;
  endsequence

  property p_alarm_kills_ct;
    @(posedge clk_i) disable iff (!arst_n_i) alarm |=> !ct_enable_o;
  endproperty
  a_alarm_kills_ct: assert property (p_alarm_kills_ct) else $error("ct on during alarm");

  property p_latch;
    @(posedge clk_i) disable iff (!arst_n_i) (alm_state == ALM_LATCHED && !alm_rst) |=> alm_state == ALM_LATCHED;
  endproperty
  a_latch: assert property (p_latch) else $error("alarm left without reset");

  property p_recheck;
    @(posedge clk_i) disable iff (!arst_n_i) s_reset_req |=> alm_state == ALM_CHECK;
  endproperty
  a_recheck: assert property (p_recheck) else $error("reset did not start recheck");

  property p_fail_stays;
    @(posedge clk_i) disable iff (!arst_n_i) (alm_state == ALM_CHECK && any_fault) |=> alm_state == ALM_LATCHED;
  endproperty
  a_fail_stays: assert property (p_fail_stays) else $error("failed recheck exited alarm");

  property p_test_inhibit;
    @(posedge clk_i) disable iff (!arst_n_i) test_mode |=> !ct_enable_o && use_test_key_o && ind_test_o;
  endproperty
  a_test_inhibit: assert property (p_test_inhibit) else $error("test mode not honoured");

  property p_key_entry;
    @(posedge clk_i) disable iff (!arst_n_i) key_entry_i |=> !ct_enable_o;
  endproperty
  a_key_entry: assert property (p_key_entry) else $error("ct on during key entry");

  property p_parity_block;
    @(posedge clk_i) disable iff (!arst_n_i) key_parity_err_i |=> !xfer_grant_o [*2];
  endproperty
  a_parity_block: assert property (p_parity_block) else $error("transfer after parity error");

  property p_relay;
    @(posedge clk_i) disable iff (!arst_n_i) relay_alarm_o == ind_alarm_o;
  endproperty
  a_relay: assert property (p_relay) else $error("relay differs from alarm lamp");

  property p_zeroize;
    @(posedge clk_i) disable iff (!arst_n_i) zero_cmd |=> ##1 wipe_we_o ##0 !ct_enable_o;
  endproperty
  a_zeroize: assert property (p_zeroize) else $error("zeroize did not start erase");

  // A live fault must drop ciphertext at the very next edge, before the latch
  property p_fault_kills_ct;
    @(posedge clk_i) disable iff (!arst_n_i) any_fault |=> !ct_enable_o;
  endproperty
  a_fault_kills_ct: assert property (p_fault_kills_ct) else $error("ct on after live fault");

  // Lamp test must light every panel lamp one edge later
  property p_lamp_all;
    @(posedge clk_i) disable iff (!arst_n_i) lamp |=> ind_power_o && ind_bypass_o && ind_test_o &&
                                                       ind_battery_o && ind_alarm_o && ind_parity_o;
  endproperty
  a_lamp_all: assert property (p_lamp_all) else $error("lamp test left a lamp dark");

  // Standby stops the engine and the ciphertext path but leaves the key alone
  property p_standby_stop;
    @(posedge clk_i) disable iff (!arst_n_i) standby |=> !engine_run_o && !ct_enable_o;
  endproperty
  a_standby_stop: assert property (p_standby_stop) else $error("engine ran in standby");

  // Power may only be dropped once the key store is clean
  property p_power_release;
    @(posedge clk_i) disable iff (!arst_n_i) (primary_off_o || battery_off_o) |-> zeroed;
  endproperty
  a_power_release: assert property (p_power_release) else $error("power dropped before erase");

  // Parity lamp comes on two edges after the error pulse: flag, then lamp
  property p_parity_lamp;
    @(posedge clk_i) disable iff (!arst_n_i) key_parity_err_i |=> ##1 ind_parity_o;
  endproperty
  a_parity_lamp: assert property (p_parity_lamp) else $error("parity lamp not lit");

endmodule : crypto_sup
`default_nettype wire

// [tb/key_loader_model.sv]
// Purpose: Key variable loader and transfer requester facing the supervisor.
// Assumes: Drives every level just after a rising edge of clk_i.
// Notes:   A bad load ends with a parity error pulse, a good one with done.
`default_nettype none
module key_loader_model (
  input  wire logic clk_i,            // Core clock
  output logic      key_entry_o,      // Entry in progress
  output logic      key_parity_err_o, // One-cycle error pulse
  output logic      key_load_done_o,  // One-cycle good-key pulse
  output logic      xfer_req_o        // Internal transfer request
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    key_entry_o      = 1'b0;
    key_parity_err_o = 1'b0;
    key_load_done_o  = 1'b0;
    xfer_req_o       = 1'b0;
  end
  // Entry stays high while the loader streams key words
  task automatic begin_entry();
    @(posedge clk_i) key_entry_o <= 1'b1;
  endtask : begin_entry
  // One pulse closes the entry; bad parity is reported instead of done
  task automatic end_entry(input logic bad);
    @(posedge clk_i);
    key_entry_o      <= 1'b0;
    key_parity_err_o <= bad;
    key_load_done_o  <= !bad;
    @(posedge clk_i);
    key_parity_err_o <= 1'b0;
    key_load_done_o  <= 1'b0;
  endtask : end_entry
endmodule : key_loader_model
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the crypto supervisor.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Waits on ciphertext enable are bounded loops.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, rd_val;
  logic wr_i = 1'b0, rd_i = 1'b0;
  logic power_sw_on_i = 1'b1, power_good_i = 1'b1, battery_ok_i = 1'b1;
  logic [crypto_sup_pkg::NUM_CHECKS-1:0] fault_i = '0;
  logic sbox_ok_i = 1'b1;
  logic key_entry_i, key_parity_err_i, key_load_done_i, xfer_req_i, xfer_grant_o;
  logic ct_enable_o, bypass_route_o, engine_run_o, use_test_key_o, primary_off_o, battery_off_o;
  logic wipe_we_o;
  logic [2:0] wipe_addr_o;
  logic [63:0] wipe_data_o;
  logic ind_power_o, ind_bypass_o, ind_test_o, ind_battery_o, ind_alarm_o, ind_parity_o, relay_alarm_o;
  int miscompares = 0, samples_checked = 0, n_wipe = 0, n_dirty = 0;
  always #2 clk_i = ~clk_i;  // 250 MHz
  ////////////////////////////////////////////////////////////////////////
  key_loader_model kvl (.clk_i(clk_i), .key_entry_o(key_entry_i), .key_parity_err_o(key_parity_err_i),
    .key_load_done_o(key_load_done_i), .xfer_req_o(xfer_req_i));
  crypto_sup dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .power_sw_on_i(power_sw_on_i), .power_good_i(power_good_i),
    .battery_ok_i(battery_ok_i), .fault_i(fault_i), .sbox_ok_i(sbox_ok_i), .key_entry_i(key_entry_i),
    .key_parity_err_i(key_parity_err_i), .key_load_done_i(key_load_done_i), .xfer_req_i(xfer_req_i),
    .xfer_grant_o(xfer_grant_o), .ct_enable_o(ct_enable_o), .bypass_route_o(bypass_route_o),
    .engine_run_o(engine_run_o), .use_test_key_o(use_test_key_o), .primary_off_o(primary_off_o),
    .battery_off_o(battery_off_o), .wipe_we_o(wipe_we_o), .wipe_addr_o(wipe_addr_o),
    .wipe_data_o(wipe_data_o), .ind_power_o(ind_power_o), .ind_bypass_o(ind_bypass_o),
    .ind_test_o(ind_test_o), .ind_battery_o(ind_battery_o), .ind_alarm_o(ind_alarm_o),
    .ind_parity_o(ind_parity_o), .relay_alarm_o(relay_alarm_o));
  // Count erase writes and any that carry a nonzero pattern or an out-of-order word address
  always @(posedge clk_i) begin
    if (wipe_we_o === 1'b1) begin
      if (wipe_data_o !== '0 || wipe_addr_o !== n_wipe[2:0]) n_dirty++;
      n_wipe++;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i) wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i) rd_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask : rd
  // Bounded wait for ciphertext enable to come back
  task automatic wait_ct();
    for (int i = 0; i < 40 && ct_enable_o !== 1'b1; i++) cyc(1);
    chk("ct_enable", ct_enable_o, 1);
  endtask : wait_ct
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // Watchdog well beyond the few hundred cycles of the sequence
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    arst_n_i <= 1'b1;
    cyc(2);
    chk("ind_power", ind_power_o, 1);
    battery_ok_i <= 1'b0;
    cyc(3);
    chk("ind_battery", ind_battery_o, 0);
    battery_ok_i <= 1'b1;
    cyc(3);
    chk("ind_battery", ind_battery_o, 1);
    rd(crypto_sup_pkg::STAT_OFS);
    chk("stat_idle", rd_val, 32'h10b);
    rd(8'h0c);
    chk("unmapped", rd_val, 0);
    wr(crypto_sup_pkg::CTRL_OFS, 32'h2);
    kvl.begin_entry();
    kvl.end_entry(1'b0);
    wait_ct();
    chk("engine_run", engine_run_o, 1);
    rd(crypto_sup_pkg::CTRL_OFS);
    chk("ctrl", rd_val, 32'h2);
    kvl.begin_entry();
    cyc(4);
    chk("ct_entry", ct_enable_o, 0);
    kvl.end_entry(1'b0);
    wait_ct();
    wr(crypto_sup_pkg::CTRL_OFS, 32'h3);
    cyc(4);
    chk("ct_standby", ct_enable_o, 0);
    chk("engine_standby", engine_run_o, 0);
    wr(crypto_sup_pkg::CTRL_OFS, 32'h2);
    wait_ct();
    wr(crypto_sup_pkg::CTRL_OFS, 32'h6);
    cyc(4);
    chk("ind_test", ind_test_o, 1);
    chk("test_key", use_test_key_o, 1);
    chk("ct_test", ct_enable_o, 0);
    sbox_ok_i <= 1'b0;
    cyc(4);
    chk("alarm_table", ind_alarm_o, 1);
    rd(crypto_sup_pkg::FAULT_OFS);
    chk("fault_table", rd_val[4], 1);
    sbox_ok_i <= 1'b1;
    wr(crypto_sup_pkg::CTRL_OFS, 32'h42);
    wait_ct();
    fault_i <= 4'h2;
    cyc(1);
    chk("ct_alarm", ct_enable_o, 0);
    chk("relay", relay_alarm_o, 1);
    fault_i <= 4'h0;
    cyc(20);
    chk("alarm_latch", ind_alarm_o, 1);
    chk("ct_latch", ct_enable_o, 0);
    chk("relay", relay_alarm_o, 1);
    rd(crypto_sup_pkg::FAULT_OFS);
    chk("fault_cause", rd_val, 32'h2);
    wr(crypto_sup_pkg::CTRL_OFS, 32'h12);
    cyc(4);
    chk("bypass_route", bypass_route_o, 1);
    chk("ind_bypass", ind_bypass_o, 1);
    wr(crypto_sup_pkg::CTRL_OFS, 32'h2);
    fault_i <= 4'h1;
    wr(crypto_sup_pkg::CTRL_OFS, 32'h42);
    cyc(5);
    chk("ct_recheck", ct_enable_o, 0);
    fault_i <= 4'h0;
    cyc(crypto_sup_pkg::RECHECK_CYC + 10);
    chk("alarm_kept", ind_alarm_o, 1);
    wr(crypto_sup_pkg::CTRL_OFS, 32'h42);
    cyc(3);
    chk("ct_recheck", ct_enable_o, 0);
    rd(crypto_sup_pkg::STAT_OFS);
    chk("stat_check", rd_val, 32'h31b);
    wait_ct();
    rd(crypto_sup_pkg::FAULT_OFS);
    chk("fault_clear", rd_val, 0);
    kvl.xfer_req_o <= 1'b1;
    cyc(3);
    chk("grant", xfer_grant_o, 1);
    kvl.begin_entry();
    kvl.end_entry(1'b1);
    cyc(12);
    chk("ind_parity", ind_parity_o, 1);
    chk("grant_lock", xfer_grant_o, 0);
    rd(crypto_sup_pkg::STAT_OFS);
    chk("stat_lock", rd_val, 32'h69);
    kvl.begin_entry();
    kvl.end_entry(1'b0);
    cyc(3);
    chk("grant_free", xfer_grant_o, 1);
    wr(crypto_sup_pkg::CTRL_OFS, 32'ha);
    cyc(3);
    chk("lamps", {ind_power_o, ind_bypass_o, ind_test_o, ind_battery_o, ind_alarm_o, ind_parity_o},
        32'h3f);
    n_wipe = 0;
    wr(crypto_sup_pkg::CTRL_OFS, 32'h82);
    cyc(20);
    chk("wipe_words", n_wipe, 4);
    chk("ct_zeroed", ct_enable_o, 0);
    n_wipe = 0;
    wr(crypto_sup_pkg::CTRL_OFS, 32'ha2);
    cyc(20);
    chk("wipe_cbc", n_wipe, crypto_sup_pkg::WIPE_WORDS);
    chk("wipe_zero", n_dirty, 0);
    power_sw_on_i <= 1'b0;
    cyc(40);
    chk("power_off", {primary_off_o, battery_off_o}, 32'h3);
    chk("ind_power_off", ind_power_o, 0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
